// ---- core/ptd_ctr_if.sv ----
// Purpose: link between register file and down-counter
// Assumes: single clock domain
// Notes:   clear is a one-cycle pulse, wrap is a one-cycle pulse except at period 1, where it stays high while enabled
`timescale 1ns/1ps
`default_nettype none
interface ptd_ctr_if;
  import ptd_pkg::*;
  logic             enable;
  logic             clear;
  logic [PER_W-1:0] period;
  logic [CNT_W-1:0] value;
  logic             wrap;

  modport regs (output enable, output clear, output period,
                input value, input wrap);
  modport ctr  (input enable, input clear, input period,
                output value, output wrap);
endinterface : ptd_ctr_if
`default_nettype wire

// ---- core/ptd_down_counter.sv ----
// Purpose: free-running periodic down-counter with reload
// Assumes: period programmed within 1..16777216
// Notes:   the reload straight after a clear raises no wrap event
`timescale 1ns/1ps
`default_nettype none
module ptd_down_counter (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  ptd_ctr_if.ctr    ctr
);
  import ptd_pkg::*;

  logic             cleared;
  logic [PER_W-1:0] per_m1;

  // reload picks up the period only here, so a new period waits
  assign per_m1 = ctr.period - PER_ONE;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctr.value <= RST_COUNT;
      cleared   <= 1'b1;
    end else if (ctr.clear) begin
      ctr.value <= CNT_ZERO;
      cleared   <= 1'b1;
    end else if (ctr.enable) begin
      if (ctr.value == CNT_ZERO) begin
        ctr.value <= per_m1[CNT_W-1:0];
        cleared   <= 1'b0;
      end else begin
        ctr.value <= ctr.value - 24'h000001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctr.wrap <= 1'b0;
    end else begin
      // one event per pass through zero gives spacing of one period
      ctr.wrap <= ~ctr.clear & ctr.enable & ~cleared &
                  (ctr.value == CNT_ZERO);
    end
  end
endmodule // ptd_down_counter
`default_nettype wire

// ---- core/ptd_irq_status.sv ----
// Purpose: sticky event flags, mask and level interrupt
// Assumes: set, clear and ack come from logic on clk_i
// Notes:   a set in the same cycle as a clear wins
`timescale 1ns/1ps
`default_nettype none
module ptd_irq_status (
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic [ptd_pkg::IRQ_N-1:0] set_i,
  input  wire logic [ptd_pkg::IRQ_N-1:0] w1c_i,
  input  wire logic                     ack_i,
  input  wire logic [ptd_pkg::IRQ_N-1:0] mask_i,
  output logic      [ptd_pkg::IRQ_N-1:0] status_o,
  output logic                          irq_o
);
  import ptd_pkg::*;

  logic [IRQ_N-1:0] clr;
  logic [IRQ_N-1:0] next_status;

  always_comb begin
    clr = w1c_i;
    // entering the handler retires the pending tick by itself
    clr[IRQ_TICK_BIT] = w1c_i[IRQ_TICK_BIT] | ack_i;
    next_status = set_i | (status_o & ~clr);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      status_o <= RST_STATUS;
    end else begin
      status_o <= next_status;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_status & mask_i);
    end
  end
endmodule // ptd_irq_status
`default_nettype wire

// ---- core/ptd_pkg.sv ----
// Purpose: shared constants for the periodic tick down-counter
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   period field holds the tick count itself, not count minus one
package ptd_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 24;
  localparam int unsigned PER_W  = 25;
  localparam int unsigned IRQ_N  = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PERIOD  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CURRENT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MSTAT   = 8'h14;

  // field positions
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_FLAG_BIT = 1;
  localparam int unsigned IRQ_TICK_BIT  = 0;
  localparam int unsigned IRQ_OVR_BIT   = 1;

  // reset values
  localparam logic              RST_EN     = 1'b0;
  localparam logic [PER_W-1:0]  RST_PERIOD = 25'h0000001;
  localparam logic [CNT_W-1:0]  RST_COUNT  = 24'h000000;
  localparam logic [IRQ_N-1:0]  RST_MASK   = 2'h0;
  localparam logic [IRQ_N-1:0]  RST_STATUS = 2'h0;

  // helpers
  localparam logic [PER_W-1:0]  PER_ONE    = 25'h0000001;
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h00000000;
endpackage : ptd_pkg

// ---- core/ptd_tick_timer.sv ----
// Purpose: register front end of the periodic tick down-counter
// Assumes: master obeys one-cycle strobes, never read and write together
// Notes:   read data valid only in the cycle after the read strobe
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ptd_tick_timer (
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic [ptd_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [ptd_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  input  wire logic                      handler_ack_i,
  output logic      [ptd_pkg::DATA_W-1:0] rd_data_o,
  output logic                           irq_o,
  output logic                           tick_o,
  output logic                           running_o
);
  import ptd_pkg::*;

  ptd_ctr_if ctr_if ();

  logic              enable;
  logic [PER_W-1:0]  period;
  logic [IRQ_N-1:0]  mask;
  logic [IRQ_N-1:0]  status;
  logic [IRQ_N-1:0]  set_ev;
  logic [IRQ_N-1:0]  w1c;
  logic              count_flag;
  logic              clear_pulse;
  logic [DATA_W-1:0] next_rd_data;

  logic wr_ctrl;
  logic wr_period;
  logic wr_current;
  logic wr_status;
  logic wr_mask;
  logic rd_ctrl;

  assign wr_ctrl    = wr_i & (addr_i == OFS_CTRL);
  assign wr_period  = wr_i & (addr_i == OFS_PERIOD);
  assign wr_current = wr_i & (addr_i == OFS_CURRENT);
  assign wr_status  = wr_i & (addr_i == OFS_STATUS);
  assign wr_mask    = wr_i & (addr_i == OFS_MASK);
  assign rd_ctrl    = rd_i & (addr_i == OFS_CTRL);

  // control: enable bit steers the counter
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      enable <= RST_EN;
    end else if (wr_ctrl) begin
      enable <= wr_data_i[CTRL_EN_BIT];
    end
  end

  // period is not range checked; keeping it legal is up to software
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      period <= RST_PERIOD;
    end else if (wr_period) begin
      period <= wr_data_i[PER_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mask <= RST_MASK;
    end else if (wr_mask) begin
      mask <= wr_data_i[IRQ_N-1:0];
    end
  end

  // data written to current is ignored, only the strobe matters
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clear_pulse <= 1'b0;
    end else begin
      clear_pulse <= wr_current;
    end
  end

  assign ctr_if.enable = enable;
  assign ctr_if.clear  = clear_pulse;
  assign ctr_if.period = period;

  ptd_down_counter u_counter (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ctr       (ctr_if)
  );

  // overrun marks a tick landing while the last is still pending
  always_comb begin
    set_ev = RST_STATUS;
    set_ev[IRQ_TICK_BIT] = ctr_if.wrap;
    set_ev[IRQ_OVR_BIT]  = ctr_if.wrap & status[IRQ_TICK_BIT] &
                           ~handler_ack_i;
  end

  assign w1c = wr_status ? wr_data_i[IRQ_N-1:0] : RST_STATUS;

  ptd_irq_status u_irq (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (set_ev),
    .w1c_i     (w1c),
    .ack_i     (handler_ack_i),
    .mask_i    (mask),
    .status_o  (status),
    .irq_o     (irq_o)
  );

  // sticky wrap flag, cleared by reading control; a wrap wins
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_flag <= 1'b0;
    end else if (ctr_if.wrap) begin
      count_flag <= 1'b1;
    end else if (rd_ctrl) begin
      count_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= ctr_if.wrap;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      running_o <= 1'b0;
    end else begin
      running_o <= enable;
    end
  end

  // reads have no side effect except the control wrap flag
  always_comb begin
    next_rd_data = DATA_ZERO;
    if (rd_i) begin
      unique case (addr_i)
        OFS_CTRL: begin
          next_rd_data[CTRL_EN_BIT]   = enable;
          next_rd_data[CTRL_FLAG_BIT] = count_flag;
        end
        OFS_PERIOD: begin
          next_rd_data[PER_W-1:0] = period;
        end
        OFS_CURRENT: begin
          next_rd_data[CNT_W-1:0] = ctr_if.value;
        end
        OFS_STATUS: begin
          next_rd_data[IRQ_N-1:0] = status;
        end
        OFS_MASK: begin
          next_rd_data[IRQ_N-1:0] = mask;
        end
        OFS_MSTAT: begin
          next_rd_data[IRQ_N-1:0] = status & mask;
        end
        default: begin
          next_rd_data = DATA_ZERO;
        end
      endcase
    end
  end

  // zero outside the answer cycle keeps stale data off the bus
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= DATA_ZERO;
    end else begin
      rd_data_o <= next_rd_data;
    end
  end
endmodule // ptd_tick_timer
`default_nettype wire

// ---- tb/ptd_chk.sv ----
// Purpose: port checker for ptd_tick_timer
// Assumes: overrun stays masked while the handler acks
// Notes:   msk mirrors the mask register from bus writes
`timescale 1ns/1ps
`default_nettype none
module ptd_chk (
  input wire logic                       clk_i,
  input wire logic                       sys_rst_i,
  input wire logic [ptd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ptd_pkg::DATA_W-1:0] wr_data_i,
  input wire logic                       wr_i,
  input wire logic                       rd_i,
  input wire logic                       handler_ack_i,
  input wire logic [ptd_pkg::DATA_W-1:0] rd_data_o,
  input wire logic                       irq_o,
  input wire logic                       tick_o,
  input wire logic                       running_o
);
  import ptd_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [IRQ_N-1:0] msk;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i)
      msk <= RST_MASK;
    else if (wr_i && addr_i == OFS_MASK)
      msk <= wr_data_i[IRQ_N-1:0];
  end
  // write then read of one place, one quiet cycle between
  sequence s_wr_rd(a);
    wr_i && addr_i == a ##1 !wr_i ##1 rd_i && addr_i == a;
  endsequence
  chk_tick_needs_run: assert property (
    tick_o |-> $past(running_o)) else $error("tick while stopped");
  chk_run_follows_ctrl: assert property (
    wr_i && addr_i == OFS_CTRL ##1 !wr_i |=>
    running_o == $past(wr_data_i[CTRL_EN_BIT], 2)) else $error("run bit");
  chk_clear_reads_zero: assert property (
    s_wr_rd(OFS_CURRENT) |=> rd_data_o == DATA_ZERO) else $error("clear");
  chk_count_width: assert property (
    $past(rd_i && addr_i == OFS_CURRENT) |-> rd_data_o[31:24] == 8'h00)
    else $error("count too wide");
  chk_irq_rise_cause: assert property (
    $rose(irq_o) |-> tick_o || $past(wr_i) || $past(wr_i, 2))
    else $error("irq without tick");
  chk_irq_masked_off: assert property (
    msk == '0 && !wr_i |=> !irq_o) else $error("masked irq");
  chk_ack_drops_irq: assert property (
    handler_ack_i && !msk[IRQ_OVR_BIT] && !wr_i |=> !irq_o || tick_o)
    else $error("ack kept irq");
  chk_period_readback: assert property (
    s_wr_rd(OFS_PERIOD) |=>
    rd_data_o == {7'h00, $past(wr_data_i[PER_W-1:0], 3)}) else $error("per");
  chk_read_idle_zero: assert property (
    !$past(rd_i) |-> rd_data_o == DATA_ZERO) else $error("idle data");
endmodule // ptd_chk
bind ptd_tick_timer ptd_chk i_ptd_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
  .handler_ack_i(handler_ack_i), .rd_data_o(rd_data_o), .irq_o(irq_o),
  .tick_o(tick_o), .running_o(running_o));
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: register-level test of the periodic tick down-counter
// Assumes: 40 MHz clock, reset held 12 cycles
// Notes:   lgap holds the cycle spacing of the last two ticks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ptd_pkg::*;
  logic              clk_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wr_data_i = '0;
  logic [DATA_W-1:0] rd_data_o, v, w;
  logic              wr_i = 1'b0, rd_i = 1'b0, handler_ack_i = 1'b0;
  logic              irq_o, tick_o, running_o;
  int                n_mismatch = 0, tests_run = 0;
  int                cyc = 0, gap = 0, lgap = 0, nt = 0;
  ptd_tick_timer i_ptd_tick_timer (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .handler_ack_i(handler_ack_i), .rd_data_o(rd_data_o), .irq_o(irq_o),
    .tick_o(tick_o), .running_o(running_o));
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask
  // own capture word, so a check never clobbers a value held in v
  task automatic rc(logic [7:0] a, logic [31:0] e, string nm);
    logic [31:0] g;
    rd(a, g);
    chk(nm, e, g);
  endtask
  // returns just after an edge that saw tick_o, once lgap has landed
  task automatic wt();
    do @(posedge clk_i); while (tick_o !== 1'b1);
    #1;
  endtask
  initial forever #12.5 clk_i = ~clk_i;
  // ceiling far above the fewer than two hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    gap <= (tick_o === 1'b1) ? 1 : gap + 1;
    if (tick_o === 1'b1) begin
      lgap <= gap;
      nt <= nt + 1;
    end
    if (cyc > 3000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rc(OFS_CTRL, 0, "ctrl");
    rc(OFS_PERIOD, 1, "period");
    rc(OFS_CURRENT, 0, "count");
    rc(OFS_MASK, 0, "mask");
    rc(8'h18, 0, "unmapped");
    wr(OFS_PERIOD, 32'h01000000);
    rc(OFS_PERIOD, 32'h01000000, "period max");
    wr(OFS_PERIOD, 5);
    wr(OFS_MASK, 1);
    wr(OFS_CTRL, 1);
    wt();
    wt();
    chk("gap", 5, lgap);
    chk("irq", 1, irq_o);
    chk("running", 1, running_o);
    @(posedge clk_i);
    handler_ack_i <= 1'b1;
    @(posedge clk_i);
    handler_ack_i <= 1'b0;
    #1 chk("irq ack", 0, irq_o);
    rd(OFS_CURRENT, v);
    rd(OFS_CURRENT, w);
    chk("range", 1, v < 5);
    chk("live", (v + 3) % 5, w);
    wt();
    wr(OFS_PERIOD, 3);
    wt();
    chk("old gap", 5, lgap);
    wt();
    chk("new gap", 3, lgap);
    wr(OFS_CTRL, 0);
    rd(OFS_CURRENT, v);
    w = nt;
    repeat (20) @(posedge clk_i);
    rc(OFS_CURRENT, v, "halted");
    chk("ticks", w, nt);
    chk("stopped", 0, running_o);
    rc(OFS_CTRL, 32'h00000002, "wrap flag");
    rc(OFS_CTRL, 0, "flag clear");
    wr(OFS_CTRL, 1);
    rc(OFS_CURRENT, (v + 2) % 3, "resume");
    // one spare edge so the stop lands on a reload and the count holds 2
    @(posedge clk_i);
    wr(OFS_CTRL, 0);
    rc(OFS_CURRENT, 2, "held");
    wr(OFS_CURRENT, 32'hffffffff);
    rc(OFS_CURRENT, 0, "cleared");
    wr(OFS_CTRL, 1);
    rc(OFS_CURRENT, 2, "reload");
    wr(OFS_MASK, 0);
    wr(OFS_STATUS, 3);
    wt();
    wt();
    chk("irq off", 0, irq_o);
    rc(OFS_STATUS, 3, "status");
    wr(OFS_MASK, 3);
    rc(OFS_MSTAT, 3, "mstat");
    chk("irq on", 1, irq_o);
    results();
  end
endmodule // tb_top
`default_nettype wire
